// *** hw/page_status_factor_load_ops.sv ***
`timescale 1ns/1ps
`include "status_load_consts.svh"
module page_status_factor_load_ops
    import status_load_pkg::*;
#(
    parameter int AW = 8
) (
    input  wire logic                       mclk,
    input  wire logic                       reset,
    input  wire logic                       instValid,
    input  wire status_load_pkg::word_t     instWord,
    input  wire logic                       intMaskSet,
    input  wire logic                       intMaskValue,
    input  wire logic                       memWrEn,
    input  wire logic [AW-1:0]              memWrAddr,
    input  wire status_load_pkg::word_t     memWrData,
    input  wire status_load_pkg::word_t     mulOutIn,
    output status_load_pkg::status_s        status,
    output status_load_pkg::word_t          savedStatusWord,
    output status_load_pkg::word_t          mulInReg,
    output logic [31:0]                     sumReg,
    output logic [AW-1:0]                   operandAddr,
    output logic                            busy
);
    import status_load_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic op_e decode(input word_t w);
        unique case (w[15:8])
            `OPC_LOAD_PAGE_MEM:    decode = OP_PAGE_MEM;
            `OPC_LOAD_PAGE_IMM:    decode = OP_PAGE_IMM;
            `OPC_RESTORE_STATUS:   decode = OP_RESTORE;
            `OPC_FETCH_FACTOR:     decode = OP_FACTOR;
            `OPC_FETCH_FACTOR_SUM: decode = OP_FACTOR_S;
            default:               decode = OP_NONE;
        endcase
    endfunction : decode

    function automatic word_t pack_status(input status_s s);
        word_t w;
        w = `ST_FILL;
        w[`ST_EXCESS_BIT] = s.excessFlag;
        w[`ST_CLAMP_BIT]  = s.clampMode;
        w[`ST_MASK_BIT]   = s.intMask;
        w[`ST_ARP_BIT]    = s.auxPtr;
        w[`ST_PAGE_BIT]   = s.pagePtr;
        return w;
    endfunction : pack_status

    // ------------------------------------------------------------
    // two-phase sequencing: address cycle, execute cycle
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        S_FETCH = 1'b0,
        S_EXEC  = 1'b1
    } phase_e;

    phase_e    phase_reg;
    op_e       op_reg;
    word_t     inst_reg;
    status_s   status_reg;
    word_t     mulIn_reg;
    logic [31:0] sum_reg;
    logic [AW-1:0] aux_reg [2];
    logic [AW-1:0] addr_reg;
    word_t     rdData;
    logic [AW-1:0] addrNext;

    always_comb
    begin
        if (instWord[`IND_BIT])
            addrNext = aux_reg[status_reg.auxPtr];
        else
            addrNext = status_reg.pagePtr ? AW'(`PAGE_BASE | {1'b0, instWord[6:0]})
                                          : AW'({1'b0, instWord[6:0]});
    end

    data_ram #(.WORDS(`DATA_WORDS), .AW(AW)) u_ram (
        .mclk   (mclk),
        .rdAddr (addrNext),
        .rdData (rdData),
        .wrEn   (memWrEn),
        .wrAddr (memWrAddr),
        .wrData (memWrData)
    );

    always_ff @(posedge mclk)
    begin
        if (reset)
            phase_reg <= S_FETCH;
        else if (phase_reg == S_FETCH && instValid)
            phase_reg <= S_EXEC;
        else
            phase_reg <= S_FETCH;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            op_reg   <= OP_NONE;
            inst_reg <= 16'h0000;
            addr_reg <= '0;
        end
        else if (phase_reg == S_FETCH && instValid)
        begin
            op_reg   <= decode(instWord);
            inst_reg <= instWord;
            addr_reg <= addrNext;
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
            status_reg <= '0;
        else if (phase_reg == S_EXEC)
        begin
            unique case (op_reg)
                OP_PAGE_MEM:
                    status_reg.pagePtr <= rdData[0];
                OP_PAGE_IMM:
                    status_reg.pagePtr <= inst_reg[`NEWPTR_BIT];
                OP_RESTORE:
                begin
                    status_reg.excessFlag <= rdData[`ST_EXCESS_BIT];
                    status_reg.clampMode  <= rdData[`ST_CLAMP_BIT];
                    status_reg.pagePtr    <= rdData[`ST_PAGE_BIT];
                    status_reg.auxPtr     <= rdData[`ST_ARP_BIT];
                end
                default:
                    status_reg.pagePtr <= status_reg.pagePtr;
            endcase
            // explicit new pointer overrides the restored one
            if (op_reg != OP_PAGE_IMM && op_reg != OP_NONE
                && inst_reg[`IND_BIT] && !inst_reg[`NOPTR_BIT])
                status_reg.auxPtr <= inst_reg[`NEWPTR_BIT];
        end
        else if (intMaskSet)
            status_reg.intMask <= intMaskValue;
    end

    // auxiliary register post-modify
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            aux_reg[0] <= '0;
            aux_reg[1] <= '0;
        end
        else if (phase_reg == S_EXEC && op_reg != OP_NONE && op_reg != OP_PAGE_IMM
                 && inst_reg[`IND_BIT])
        begin
            if (inst_reg[`INC_BIT])
                aux_reg[status_reg.auxPtr] <= addr_reg + AW'(1);
            else if (inst_reg[`DEC_BIT])
                aux_reg[status_reg.auxPtr] <= addr_reg - AW'(1);
        end
    end

    // ------------------------------------------------------------
    // factor and sum
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (reset)
            mulIn_reg <= 16'h0000;
        else if (phase_reg == S_EXEC && (op_reg == OP_FACTOR || op_reg == OP_FACTOR_S))
            mulIn_reg <= rdData;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            sum_reg <= 32'h0000_0000;
        else if (phase_reg == S_EXEC && op_reg == OP_FACTOR_S)
            sum_reg <= sum_reg + {{16{mulOutIn[15]}}, mulOutIn};
    end

    assign status          = status_reg;
    assign savedStatusWord = pack_status(status_reg);
    assign mulInReg        = mulIn_reg;
    assign sumReg          = sum_reg;
    assign operandAddr     = addr_reg;
    assign busy            = (phase_reg == S_EXEC);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence restoreExec;
        phase_reg == S_EXEC && op_reg == OP_RESTORE;
    endsequence

    page_mem_a: assert property (@(posedge mclk) disable iff (reset)
        phase_reg == S_EXEC && op_reg == OP_PAGE_MEM |=> status_reg.pagePtr == $past(rdData[0]))
        else $error("page pointer not from bit 0");
    page_imm_a: assert property (@(posedge mclk) disable iff (reset)
        phase_reg == S_EXEC && op_reg == OP_PAGE_IMM
        |=> status_reg.pagePtr == $past(inst_reg[`NEWPTR_BIT]))
        else $error("page pointer not from immediate");
    restore_mask_a: assert property (@(posedge mclk) disable iff (reset)
        restoreExec |=> $stable(status_reg.intMask))
        else $error("restore changed interrupt mask");
    restore_excess_a: assert property (@(posedge mclk) disable iff (reset)
        restoreExec |=> status_reg.excessFlag == $past(rdData[`ST_EXCESS_BIT]))
        else $error("excess flag not restored");
    restore_page_a: assert property (@(posedge mclk) disable iff (reset)
        restoreExec |=> status_reg.pagePtr == $past(rdData[`ST_PAGE_BIT]))
        else $error("page pointer not restored");
    restore_aux_a: assert property (@(posedge mclk) disable iff (reset)
        restoreExec ##0 !inst_reg[`IND_BIT]
        |=> status_reg.auxPtr == $past(rdData[`ST_ARP_BIT]))
        else $error("aux pointer not restored");
    new_pointer_a: assert property (@(posedge mclk) disable iff (reset)
        phase_reg == S_EXEC && op_reg == OP_FACTOR && inst_reg[`IND_BIT] && !inst_reg[`NOPTR_BIT]
        |=> status_reg.auxPtr == $past(inst_reg[`NEWPTR_BIT]))
        else $error("aux pointer not reloaded");
    fsum_load_a: assert property (@(posedge mclk) disable iff (reset)
        phase_reg == S_EXEC && op_reg == OP_FACTOR_S |=> mulIn_reg == $past(rdData))
        else $error("factor register not loaded by sum variant");
    save_fill_a: assert property (@(posedge mclk) disable iff (reset)
        (savedStatusWord & `ST_FILL) == `ST_FILL)
        else $error("saved status filler bits not ones");
    factor_load_a: assert property (@(posedge mclk) disable iff (reset)
        phase_reg == S_EXEC && op_reg == OP_FACTOR |=> mulIn_reg == $past(rdData))
        else $error("factor register not loaded");
    factor_hold_a: assert property (@(posedge mclk) disable iff (reset)
        phase_reg == S_EXEC && op_reg == OP_FACTOR |=> $stable(sum_reg))
        else $error("fetch factor changed sum");
    sum_add_a: assert property (@(posedge mclk) disable iff (reset)
        phase_reg == S_EXEC && op_reg == OP_FACTOR_S
        |=> sum_reg == $past(sum_reg) + {{16{$past(mulOutIn[15])}}, $past(mulOutIn)})
        else $error("sum not accumulated");
    one_cycle_a: assert property (@(posedge mclk) disable iff (reset)
        phase_reg == S_EXEC |=> phase_reg == S_FETCH)
        else $error("execute longer than one cycle");
endmodule : page_status_factor_load_ops

// *** hw/status_load_consts.svh ***
`ifndef STATUS_LOAD_CONSTS_SVH
`define STATUS_LOAD_CONSTS_SVH

// opcode upper bytes (bits 15:8)
`define OPC_LOAD_PAGE_MEM   8'h6F
`define OPC_LOAD_PAGE_IMM   8'h6E
`define OPC_RESTORE_STATUS  8'h7B
`define OPC_FETCH_FACTOR    8'h6A
`define OPC_FETCH_FACTOR_SUM 8'h6C
// instruction word fields
`define IND_BIT             7
`define INC_BIT             5
`define DEC_BIT             4
`define NOPTR_BIT           3
`define NEWPTR_BIT          0
// saved status word layout
`define ST_EXCESS_BIT       15
`define ST_CLAMP_BIT        14
`define ST_MASK_BIT         13
`define ST_ARP_BIT          8
`define ST_PAGE_BIT         0
`define ST_FILL             16'h1EFE
`define PAGE_BASE           8'h80
// data memory depth: page 0 plus the short upper page
`define DATA_WORDS          144

`endif

// *** hw/status_load_pkg.sv ***
package status_load_pkg;
    typedef logic [15:0] word_t;

    typedef enum logic [2:0] {
        OP_NONE     = 3'b000,
        OP_PAGE_MEM = 3'b001,
        OP_PAGE_IMM = 3'b010,
        OP_RESTORE  = 3'b011,
        OP_FACTOR   = 3'b100,
        OP_FACTOR_S = 3'b101
    } op_e;

    typedef struct packed {
        logic excessFlag;
        logic clampMode;
        logic intMask;
        logic auxPtr;
        logic pagePtr;
    } status_s;
endpackage : status_load_pkg

// *** hw/data_ram.sv ***
`timescale 1ns/1ps
module data_ram #(
    parameter int WORDS = 144,
    parameter int AW    = 8
) (
    input  wire logic                       mclk,
    input  wire logic [AW-1:0]              rdAddr,
    output logic      [15:0]                rdData,
    input  wire logic                       wrEn,
    input  wire logic [AW-1:0]              wrAddr,
    input  wire logic [15:0]                wrData
);
    logic [15:0] mem [WORDS];

    always_ff @(posedge mclk)
    begin
        if (wrEn)
            mem[wrAddr] <= wrData;
    end

    always_ff @(posedge mclk)
    begin
        rdData <= mem[rdAddr];
    end
endmodule : data_ram

// *** test/prog_mem_model.sv ***
`timescale 1ns/1ps
module prog_mem_model (
    input  wire logic              mclk,
    input  wire logic              busy,
    output logic                   instValid,
    output status_load_pkg::word_t instWord
);
    import status_load_pkg::*;
    // ----------------
    // program word source
    // ----------------
    initial
    begin
        instValid = 1'b0;
        instWord  = 16'h0000;
    end
    // released word bus shows the inverse of the last word
    task automatic issue(input word_t w);
        @(negedge mclk);
        while (busy !== 1'b0)
            @(negedge mclk);
        instValid = 1'b1;
        instWord  = w;
        @(negedge mclk);
        instValid = 1'b0;
        instWord  = ~w;
    endtask : issue
endmodule : prog_mem_model

// *** test/testbench.sv ***
`timescale 1ns/1ps
`include "status_load_consts.svh"
module testbench;
    import status_load_pkg::*;
    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        instValid;
    word_t       instWord;
    logic        intMaskSet = 1'b0;
    logic        intMaskValue = 1'b0;
    logic        memWrEn = 1'b0;
    logic [7:0]  memWrAddr = 8'h00;
    word_t       memWrData = 16'h0000;
    word_t       mulOutIn = 16'h0000;
    status_s     status;
    word_t       savedStatusWord;
    word_t       mulInReg;
    logic [31:0] sumReg;
    logic [7:0]  operandAddr;
    logic        busy;
    int          nErrors = 0;
    int          testsRun = 0;
    int          cycles = 0;

    page_status_factor_load_ops #(.AW(8)) i_page_status_factor_load_ops (
        .mclk, .reset, .instValid, .instWord, .intMaskSet, .intMaskValue,
        .memWrEn, .memWrAddr, .memWrData, .mulOutIn, .status,
        .savedStatusWord, .mulInReg, .sumReg, .operandAddr, .busy);
    prog_mem_model i_prog_mem_model (.mclk, .busy, .instValid, .instWord);

    // ----------------
    // clock, timeout and tasks
    // ----------------
    always #5 mclk = ~mclk;

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            nErrors++;
            stopTest();
        end
    end

    task automatic stopTest();
        $display("errors %0d compares %0d", nErrors, testsRun);
        if (nErrors == 0 && testsRun > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stopTest

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            nErrors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input word_t d);
        @(negedge mclk);
        memWrEn = 1'b1;
        memWrAddr = a;
        memWrData = d;
        @(negedge mclk);
        memWrEn = 1'b0;
    endtask : wr

    task automatic setMask(input logic v);
        @(negedge mclk);
        intMaskSet = 1'b1;
        intMaskValue = v;
        @(negedge mclk);
        intMaskSet = 1'b0;
    endtask : setMask

    // ea below zero skips the operand address compare
    task automatic run(input word_t w, input int ea);
        i_prog_mem_model.issue(w);
        chk({31'h0, busy}, 32'h1);
        if (ea >= 0)
            chk({24'h0, operandAddr}, ea);
        @(negedge mclk);
        chk({31'h0, busy}, 32'h0);
    endtask : run

    initial
    begin
        repeat (12) @(negedge mclk);
        reset = 1'b0;
        chk({27'h0, status}, 32'h0);
        chk({16'h0, savedStatusWord}, 32'h1EFE);
        wr(8'h05, 16'hABCD);
        wr(8'h85, 16'hFFFE);
        wr(8'h06, 16'h1234);
        wr(8'h07, 16'h5555);
        wr(8'h08, 16'h7777);
        wr(8'h09, 16'hC101);
        wr(8'h8A, 16'h2000);
        wr(8'h00, 16'h00F0);
        wr(8'h01, 16'h0F00);
        run({`OPC_LOAD_PAGE_MEM, 8'h05}, 5);
        chk({31'h0, status.pagePtr}, 32'h1);
        run({`OPC_LOAD_PAGE_MEM, 8'h05}, 8'h85);
        chk({31'h0, status.pagePtr}, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            run({`OPC_LOAD_PAGE_IMM, 7'h00, ~i[0]}, -1);
            chk({31'h0, status.pagePtr}, {31'h0, ~i[0]});
        end
        setMask(1'b1);
        run({`OPC_RESTORE_STATUS, 8'h09}, 9);
        chk({27'h0, status}, 32'h1F);
        chk({16'h0, savedStatusWord}, 32'hFFFF);
        setMask(1'b0);
        run({`OPC_RESTORE_STATUS, 8'h0A}, 8'h8A);
        chk({27'h0, status}, 32'h0);
        chk({16'h0, savedStatusWord}, 32'h1EFE);
        mulOutIn = 16'hFFFF;
        run({`OPC_FETCH_FACTOR, 8'h06}, 6);
        chk({16'h0, mulInReg}, 32'h1234);
        chk(sumReg, 32'h0);
        run({`OPC_FETCH_FACTOR_SUM, 8'h07}, 7);
        chk({16'h0, mulInReg}, 32'h5555);
        chk(sumReg, 32'hFFFFFFFF);
        mulOutIn = 16'h0010;
        run({`OPC_FETCH_FACTOR_SUM, 8'h05}, 5);
        chk(sumReg, 32'h0000000F);
        run({`OPC_FETCH_FACTOR, 8'h08}, 8);
        chk({16'h0, mulInReg}, 32'h7777);
        chk(sumReg, 32'h0000000F);
        run({`OPC_FETCH_FACTOR, 8'hA1}, 0);
        chk({31'h0, status.auxPtr}, 32'h1);
        chk({16'h0, mulInReg}, 32'h00F0);
        run({`OPC_FETCH_FACTOR, 8'h80}, 0);
        chk({31'h0, status.auxPtr}, 32'h0);
        run({`OPC_FETCH_FACTOR, 8'h88}, 1);
        chk({16'h0, mulInReg}, 32'h0F00);
        stopTest();
    end
endmodule : testbench
